// ---- design/sic_pkg.sv ----
// package: constants, states and carriers of the solenoid interlock controller
package sic_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned TICK_US       = 1000;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TEACH_S       = 10;
	localparam int unsigned TEACH_MS      = TEACH_S * 1000;
	localparam int unsigned POWER_OFF_MIN = 5;
	localparam int unsigned POWER_OFF_MS  = POWER_OFF_MIN * 60_000;
	localparam int unsigned INHIBIT_MIN   = 10;
	localparam int unsigned INHIBIT_MS    = INHIBIT_MIN * 60_000;
	localparam int unsigned WARN_MIN      = 30;
	localparam int unsigned WARN_MS       = WARN_MIN * 60_000;
	localparam int unsigned BLINK1_HZ     = 1;
	localparam logic [9:0]  BLINK1_PER    = 10'(1000 / BLINK1_HZ);
	localparam logic [9:0]  BLINK1_ON     = 10'(500 / BLINK1_HZ);
	localparam int unsigned BLINK3_HZ     = 3;
	localparam logic [9:0]  BLINK3_PER    = 10'(1000 / BLINK3_HZ);
	localparam logic [9:0]  BLINK3_ON     = 10'(250 / BLINK3_HZ);
	localparam int unsigned FLASH_ON_MS   = 200;
	localparam int unsigned FLASH_SLOT_MS = 400;
	localparam logic [8:0]  FLASH_ON      = 9'(FLASH_ON_MS);
	localparam logic [8:0]  FLASH_SLOT    = 9'(FLASH_SLOT_MS);
	localparam logic [3:0]  FLASH_PAUSE   = 4'h3;
	// ************************************************************
	// red flash codes
	// ************************************************************
	localparam logic [2:0] CODE_NONE     = 3'h0;
	localparam logic [2:0] CODE_OUT_A    = 3'h1;
	localparam logic [2:0] CODE_OUT_B    = 3'h2;
	localparam logic [2:0] CODE_CROSS    = 3'h3;
	localparam logic [2:0] CODE_TEMP     = 3'h4;
	localparam logic [2:0] CODE_ACTUATOR = 3'h5;
	localparam logic [2:0] CODE_HANDLE   = 3'h6;
	localparam logic [2:0] CODE_INTERNAL = 3'h7;
	// ************************************************************
	// carriers
	// ************************************************************
	localparam int ACT_CODE_W = 8;
	typedef struct packed {
		logic test_fail_a;
		logic test_fail_b;
		logic volt_a;
		logic volt_b;
		logic cross_short;
		logic over_temp;
		logic rfid_fault;
		logic internal_fault;
	} sic_fault_t;
	typedef struct packed {
		logic [ACT_CODE_W-1:0] code;
		logic                  valid;
		logic                  pending;
		logic                  inhibit;
	} sic_nv_t;
	typedef struct packed {
		logic green;
		logic red;
		logic yellow;
	} sic_led_t;
	localparam sic_nv_t  NV_RESET  = '0;
	localparam sic_led_t LED_RESET = '0;
	typedef enum logic [2:0] {ST_LOAD, ST_RUN, ST_TEACH, ST_OFF_REQ, ST_ABORT} sic_state_t;
endpackage

// ---- design/sic_controller.sv ----
// module: supervisory state machine of the solenoid interlock
// Functional notes
// - actuator in range after power-up on coded unit: teach, green off, red on, yellow 1 Hz
// - after ten seconds of teach, yellow short 3 Hz blinks request power removal
// - no power removal within five minutes: abort teach, show five red flashes
// - after power returns, learned code is activated only when that actuator is seen again
// - one-time variant keeps pairing; repeatable variant allows unlimited re-teach
// - teaching a new actuator invalidates the old stored code
// - after re-teach hold ten-minute inhibit; green blinks until expiry and detection
// - power loss during inhibit restarts the full ten minutes
// - no locking while rotary handle is in an intermediate position
// - magnet command unlocks (power to unlock) or locks (power to lock)
// - lock-monitoring variant: outputs off on unlock, back on when relocked
// - door-monitoring variant: outputs off only when the guard opens
// - safety input missing: green blinks 1 Hz, red off, yellow shows guard state
// - internal error disables outputs; cleared by opening and re-closing guard
// - warning drops diagnostic output; after thirty minutes outputs switch off
// - a warning clears itself once its cause is gone
// - diagnostic and output levels follow guard open, closed, unlockable, locked
// - warnings flash 1 to 4 red pulses and escalate after thirty minutes
// - immediate faults flash 5 or 6 pulses; internal defect shows continuous red
// - output fault on failed self-test or voltage on a disabled output
`timescale 1ns/1ps
`default_nettype none
module sic_controller #(
	parameter int unsigned TICK_CYCLES  = sic_pkg::TICK_CYC,
	parameter int unsigned TEACH_TICKS  = sic_pkg::TEACH_MS,
	parameter int unsigned POWEROFF_TKS = sic_pkg::POWER_OFF_MS,
	parameter int unsigned INHIBIT_TKS  = sic_pkg::INHIBIT_MS,
	parameter int unsigned WARN_TICKS   = sic_pkg::WARN_MS
) (
	input  wire logic                             mclk,
	input  wire logic                             reset,
	input  wire logic                             individual_coded,
	input  wire logic                             teach_repeatable,
	input  wire logic                             power_to_lock,
	input  wire logic                             door_monitor,
	input  wire logic                             safety_input_a,
	input  wire logic                             safety_input_b,
	input  wire logic                             magnet_cmd,
	input  wire logic                             actuator_in_range,
	input  wire logic [sic_pkg::ACT_CODE_W-1:0]   act_code,
	input  wire logic                             guard_closed,
	input  wire logic                             guard_locked,
	input  wire logic                             handle_defined,
	input  wire sic_pkg::sic_fault_t              faults,
	input  wire sic_pkg::sic_nv_t                 nv_in,
	output var  sic_pkg::sic_nv_t                 nv_out,
	output logic                                  nv_write,
	output logic                                  safety_output_a,
	output logic                                  safety_output_b,
	output logic                                  diag_output,
	output logic                                  lock_drive,
	output var  sic_pkg::sic_led_t                leds
);
	// ************************************************************
	// time base: millisecond tick, blink patterns, flash codes
	// ************************************************************
	logic [31:0] tick_cnt, next_tick_cnt;
	logic        tick, next_tick;
	logic [9:0]  b1_ms, next_b1_ms, b3_ms, next_b3_ms;
	logic [8:0]  fl_sub, next_fl_sub;
	logic [3:0]  fl_idx, next_fl_idx;
	logic [2:0]  fl_n, next_fl_n;
	logic [2:0]  code_show;
	logic        blink1, blink3, flash_on;

	always_comb begin
		next_tick_cnt = tick_cnt + 32'h1;
		next_tick     = 1'b0;
		if (tick_cnt == TICK_CYCLES - 1) begin
			next_tick_cnt = '0;
			next_tick     = 1'b1;
		end
		next_b1_ms  = b1_ms;
		next_b3_ms  = b3_ms;
		next_fl_sub = fl_sub;
		next_fl_idx = fl_idx;
		next_fl_n   = fl_n;
		if (code_show != fl_n) begin
			// restart the burst so a new code is never shown truncated
			next_fl_n   = code_show;
			next_fl_sub = '0;
			next_fl_idx = '0;
		end else if (tick) begin
			next_b1_ms  = (b1_ms == sic_pkg::BLINK1_PER - 10'h1) ? 10'h0 : b1_ms + 10'h1;
			next_b3_ms  = (b3_ms == sic_pkg::BLINK3_PER - 10'h1) ? 10'h0 : b3_ms + 10'h1;
			next_fl_sub = fl_sub + 9'h1;
			if (fl_sub == sic_pkg::FLASH_SLOT - 9'h1) begin
				next_fl_sub = '0;
				next_fl_idx = fl_idx + 4'h1;
				if (fl_idx == {1'b0, fl_n} + sic_pkg::FLASH_PAUSE - 4'h1) begin
					next_fl_idx = '0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
			b1_ms    <= '0;
			b3_ms    <= '0;
			fl_sub   <= '0;
			fl_idx   <= '0;
			fl_n     <= sic_pkg::CODE_NONE;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick     <= next_tick;
			b1_ms    <= next_b1_ms;
			b3_ms    <= next_b3_ms;
			fl_sub   <= next_fl_sub;
			fl_idx   <= next_fl_idx;
			fl_n     <= next_fl_n;
		end
	end

	assign blink1   = b1_ms < sic_pkg::BLINK1_ON;
	assign blink3   = b3_ms < sic_pkg::BLINK3_ON;
	assign flash_on = (fl_idx < {1'b0, fl_n}) && (fl_sub < sic_pkg::FLASH_ON);

	// ************************************************************
	// supervision: teach-in, faults, lock and outputs
	// ************************************************************
	sic_pkg::sic_state_t st, next_st;
	sic_pkg::sic_nv_t    next_nv_out;
	sic_pkg::sic_led_t   next_leds;
	logic [31:0] st_ms, next_st_ms, inh_ms, next_inh_ms, warn_ms, next_warn_ms;
	logic [2:0]  err_code, next_err_code, warn_code, err_cause;
	logic        seen_ok, next_seen_ok, seen_open, next_seen_open;
	logic        next_nv_write, next_safe, next_diag, next_lock;
	logic        fault_a, fault_b, lock_req, inputs_ok, code_match, actuator_ok;
	logic        teach_ok, wrong_act, warn_exp, handle_fault;

	always_comb begin
		fault_a      = faults.test_fail_a | (faults.volt_a & ~safety_output_a);
		fault_b      = faults.test_fail_b | (faults.volt_b & ~safety_output_b);
		lock_req     = power_to_lock ? magnet_cmd : ~magnet_cmd;
		inputs_ok    = safety_input_a & safety_input_b;
		code_match   = act_code == nv_out.code;
		actuator_ok  = actuator_in_range & (~individual_coded | (nv_out.valid & code_match));
		teach_ok     = individual_coded & actuator_in_range & ~seen_ok & ~code_match
		             & (teach_repeatable | ~nv_out.valid);
		wrong_act    = individual_coded & actuator_in_range & ~actuator_ok & ~teach_ok
		             & ~(nv_out.pending & code_match);
		handle_fault = guard_closed & lock_req & ~handle_defined;
		if (faults.cross_short | (fault_a & fault_b))
			warn_code = sic_pkg::CODE_CROSS;
		else if (fault_a)
			warn_code = sic_pkg::CODE_OUT_A;
		else if (fault_b)
			warn_code = sic_pkg::CODE_OUT_B;
		else if (faults.over_temp)
			warn_code = sic_pkg::CODE_TEMP;
		else
			warn_code = sic_pkg::CODE_NONE;
		if (faults.internal_fault)
			err_cause = sic_pkg::CODE_INTERNAL;
		else if (handle_fault)
			err_cause = sic_pkg::CODE_HANDLE;
		else if (faults.rfid_fault | (wrong_act & st == sic_pkg::ST_RUN))
			err_cause = sic_pkg::CODE_ACTUATOR;
		else
			err_cause = sic_pkg::CODE_NONE;
		warn_exp = warn_ms >= WARN_TICKS;
		if (st == sic_pkg::ST_ABORT)
			code_show = sic_pkg::CODE_ACTUATOR;
		else if (err_code != sic_pkg::CODE_NONE)
			code_show = err_code;
		else
			code_show = warn_code;

		next_st       = st;
		next_nv_out   = nv_out;
		next_nv_write = 1'b0;
		next_seen_ok  = seen_ok;
		next_st_ms    = tick ? st_ms + 32'h1 : st_ms;
		next_inh_ms   = inh_ms;
		unique case (st)
			sic_pkg::ST_LOAD: begin
				next_nv_out = nv_in;
				next_st     = sic_pkg::ST_RUN;
			end
			sic_pkg::ST_RUN: begin
				next_st_ms = '0;
				if (actuator_ok)
					next_seen_ok = 1'b1;
				if (teach_ok) begin
					next_st = sic_pkg::ST_TEACH;
				end else if (individual_coded & nv_out.pending & actuator_in_range & code_match) begin
					next_nv_out.valid   = 1'b1;
					next_nv_out.pending = 1'b0;
					next_nv_write       = 1'b1;
				end
				// inhibit counts from zero after every power-up
				if (nv_out.inhibit) begin
					next_inh_ms = tick ? inh_ms + 32'h1 : inh_ms;
					if (inh_ms >= INHIBIT_TKS) begin
						next_nv_out.inhibit = 1'b0;
						next_nv_write       = 1'b1;
					end
				end
			end
			sic_pkg::ST_TEACH: begin
				if (st_ms >= TEACH_TICKS) begin
					next_st        = sic_pkg::ST_OFF_REQ;
					next_st_ms     = '0;
					next_nv_out    = '{code: act_code, valid: 1'b0, pending: 1'b1,
					                   inhibit: nv_out.valid | nv_out.inhibit};
					next_nv_write  = 1'b1;
				end
			end
			sic_pkg::ST_OFF_REQ: begin
				if (st_ms >= POWEROFF_TKS) begin
					next_st             = sic_pkg::ST_ABORT;
					next_nv_out.pending = 1'b0;
					next_nv_write       = 1'b1;
				end
			end
			sic_pkg::ST_ABORT: begin
				next_st_ms = st_ms;
			end
		endcase
		// warning timer is held at zero whenever no warning is present
		next_warn_ms = '0;
		if (warn_code != sic_pkg::CODE_NONE)
			next_warn_ms = (tick & ~warn_exp) ? warn_ms + 32'h1 : warn_ms;
		// a new cause wins over the reopen clear
		next_seen_open = seen_open;
		next_err_code  = err_code;
		if (err_cause != sic_pkg::CODE_NONE) begin
			next_err_code = err_cause;
		end else if (err_code != sic_pkg::CODE_NONE) begin
			if (!guard_closed)
				next_seen_open = 1'b1;
			else if (seen_open) begin
				next_err_code  = sic_pkg::CODE_NONE;
				next_seen_open = 1'b0;
			end
		end
		next_lock = guard_closed & handle_defined & lock_req;
		next_safe = inputs_ok & actuator_ok & ~nv_out.inhibit & ~nv_out.pending
		          & (st == sic_pkg::ST_RUN) & (err_code == sic_pkg::CODE_NONE)
		          & (err_cause == sic_pkg::CODE_NONE) & ~warn_exp
		          & guard_closed & (door_monitor | guard_locked);
		next_diag = guard_closed & handle_defined & (warn_code == sic_pkg::CODE_NONE)
		          & (err_code == sic_pkg::CODE_NONE) & (err_cause == sic_pkg::CODE_NONE)
		          & (st == sic_pkg::ST_RUN) & ~nv_out.inhibit;
		next_leds = '{green: 1'b1, red: 1'b0, yellow: 1'b0};
		if (st == sic_pkg::ST_TEACH || st == sic_pkg::ST_OFF_REQ) begin
			next_leds.green  = 1'b0;
			next_leds.red    = 1'b1;
			next_leds.yellow = (st == sic_pkg::ST_TEACH) ? blink1 : blink3;
		end else begin
			if (!inputs_ok || nv_out.inhibit || nv_out.pending)
				next_leds.green = blink1;
			if (code_show == sic_pkg::CODE_INTERNAL)
				next_leds.red = 1'b1;
			else if (code_show != sic_pkg::CODE_NONE)
				next_leds.red = flash_on;
			if (st == sic_pkg::ST_ABORT || err_code != sic_pkg::CODE_NONE || !guard_closed)
				next_leds.yellow = 1'b0;
			else
				next_leds.yellow = guard_locked ? 1'b1 : blink1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st              <= sic_pkg::ST_LOAD;
			nv_out          <= sic_pkg::NV_RESET;
			nv_write        <= 1'b0;
			seen_ok         <= 1'b0;
			seen_open       <= 1'b0;
			st_ms           <= '0;
			inh_ms          <= '0;
			warn_ms         <= '0;
			err_code        <= sic_pkg::CODE_NONE;
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
			diag_output     <= 1'b0;
			lock_drive      <= 1'b0;
			leds            <= sic_pkg::LED_RESET;
		end else begin
			st              <= next_st;
			nv_out          <= next_nv_out;
			nv_write        <= next_nv_write;
			seen_ok         <= next_seen_ok;
			seen_open       <= next_seen_open;
			st_ms           <= next_st_ms;
			inh_ms          <= next_inh_ms;
			warn_ms         <= next_warn_ms;
			err_code        <= next_err_code;
			safety_output_a <= next_safe;
			safety_output_b <= next_safe;
			diag_output     <= next_diag;
			lock_drive      <= next_lock;
			leds            <= next_leds;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	teach_leds_a: assert property (st == sic_pkg::ST_TEACH |=> leds.red && !leds.green)
		else $error("teach-in LED pattern wrong");
	abort_outputs_a: assert property (st == sic_pkg::ST_ABORT |=> !safety_output_a && fl_n == 3'h5)
		else $error("aborted teach-in not reported");
	inhibit_off_a: assert property (nv_out.inhibit |=> !safety_output_a && !safety_output_b)
		else $error("outputs on during inhibit");
	handle_lock_a: assert property (!handle_defined |=> !lock_drive)
		else $error("locking with handle in intermediate position");
	lock_cmd_a: assert property (guard_closed && handle_defined
		&& (magnet_cmd == power_to_lock) |=> lock_drive)
		else $error("lock command not followed");
	unlock_off_a: assert property (!door_monitor && !guard_locked |=> !safety_output_a)
		else $error("outputs on while unlocked");
	error_off_a: assert property (err_code != 3'h0 |=> !safety_output_a && !safety_output_b)
		else $error("outputs on during error");
	warn_diag_a: assert property (warn_code != 3'h0 |=> !diag_output)
		else $error("diagnostic output on during warning");
	warn_expire_a: assert property (warn_exp |=> !safety_output_a)
		else $error("warning did not escalate");
	open_off_a: assert property (!guard_closed |=> !safety_output_a && !diag_output)
		else $error("outputs on with guard open");
	pause_dark_a: assert property (st == sic_pkg::ST_RUN && fl_n != 3'h7
		&& fl_idx >= {1'b0, fl_n} && code_show == fl_n && $stable(fl_n) |=> !leds.red)
		else $error("red on during flash pause");
	teach_seen_c: cover property (st == sic_pkg::ST_TEACH ##1 st == sic_pkg::ST_OFF_REQ);
	activate_c: cover property (nv_out.pending ##1 nv_out.valid && !nv_out.pending);
	escalate_c: cover property (warn_code != 3'h0 && !warn_exp ##1 warn_exp);
	error_clear_c: cover property (err_code != 3'h0 ##1 err_code == 3'h0);
endmodule
`default_nettype wire

// ---- verif/sic_far_side.sv ----
// partner model: nonvolatile code store and door bolt mechanics seen by the interlock
`timescale 1ns/1ps
`default_nettype none
module sic_far_side (
	input  wire logic             mclk,
	input  wire logic             guard_closed,
	input  wire logic             lock_drive,
	input  wire logic             nv_write,
	input  wire sic_pkg::sic_nv_t nv_out,
	output var  sic_pkg::sic_nv_t nv_in,
	output logic                  guard_locked
);
	// ************************************************************
	// nonvolatile store
	// ************************************************************
	// survives power cycles, so it ignores the controller reset
	initial nv_in = sic_pkg::NV_RESET;
	always @(posedge mclk) begin
		if (nv_write === 1'b1) begin
			nv_in <= nv_out;
		end
	end
	// ************************************************************
	// bolt
	// ************************************************************
	// the bolt only engages a closed door and needs one cycle of travel
	initial guard_locked = 1'b0;
	always @(posedge mclk) begin
		guard_locked <= guard_closed & lock_drive;
	end
endmodule
`default_nettype wire

// ---- verif/test_solenoid_interlock_controller.sv ----
// testbench: self-checking bench of the solenoid interlock controller
`timescale 1ns/1ps
`default_nettype none
module test_solenoid_interlock_controller;
	localparam int TK    = 4;
	localparam int TEACH = 20;
	localparam int POFF  = 40;
	localparam int INH   = 30;
	localparam int WARN  = 30;
	localparam int SLOT  = 400 * TK;
	logic mclk = 1'b0, reset = 1'b1, individual_coded = 1'b0, teach_repeatable = 1'b0;
	logic power_to_lock = 1'b0, door_monitor = 1'b0, magnet_cmd = 1'b1, lreq = 1'b0;
	logic safety_input_a = 1'b1, safety_input_b = 1'b1, actuator_in_range = 1'b1;
	logic guard_closed = 1'b1, handle_defined = 1'b1;
	logic [7:0] act_code = 8'h00;
	logic [7:0] c;
	logic [31:0] rng = 32'h740B;
	sic_pkg::sic_fault_t faults = '0;
	sic_pkg::sic_nv_t    nv_in, nv_out;
	sic_pkg::sic_led_t   leds;
	logic nv_write, safety_output_a, safety_output_b, diag_output, lock_drive, guard_locked;
	logic [7:0] wmask [4] = '{8'h80, 8'h40, 8'h08, 8'h04};
	int error_cnt = 0;
	int cmp_count = 0;
	int n, took;
	sic_controller #(.TICK_CYCLES(TK), .TEACH_TICKS(TEACH), .POWEROFF_TKS(POFF),
		.INHIBIT_TKS(INH), .WARN_TICKS(WARN)) dut (.mclk(mclk), .reset(reset),
		.individual_coded(individual_coded), .teach_repeatable(teach_repeatable),
		.power_to_lock(power_to_lock), .door_monitor(door_monitor),
		.safety_input_a(safety_input_a), .safety_input_b(safety_input_b),
		.magnet_cmd(magnet_cmd), .actuator_in_range(actuator_in_range), .act_code(act_code),
		.guard_closed(guard_closed), .guard_locked(guard_locked),
		.handle_defined(handle_defined), .faults(faults), .nv_in(nv_in), .nv_out(nv_out),
		.nv_write(nv_write), .safety_output_a(safety_output_a),
		.safety_output_b(safety_output_b), .diag_output(diag_output),
		.lock_drive(lock_drive), .leds(leds));
	sic_far_side far (.mclk(mclk), .guard_closed(guard_closed), .lock_drive(lock_drive),
		.nv_write(nv_write), .nv_out(nv_out), .nv_in(nv_in), .guard_locked(guard_locked));
	initial begin
		forever #4 mclk = ~mclk;
	end
	// ************************************************************
	// helpers and reference model
	// ************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic sic_pkg::sic_nv_t mk_nv(input logic [7:0] k, input logic v,
		input logic p, input logic i);
		return sic_pkg::sic_nv_t'{k, v, p, i};
	endfunction
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %b want %b", $time, what, got, exp);
		end
	endtask
	task automatic chk_nv(input sic_pkg::sic_nv_t got, input sic_pkg::sic_nv_t exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t stored image got %h want %h", $time, got, exp);
		end
	endtask
	// expected levels from guard state, lock request, config and fault history
	task automatic chk_out(input logic err, input logic warn, input logic wexp);
		logic lk, sf;
		lk = guard_closed && handle_defined && lreq;
		sf = safety_input_a && safety_input_b && guard_closed && !err && !wexp
			&& (door_monitor || lk);
		chk("safety a", safety_output_a, sf);
		chk("safety b", safety_output_b, sf);
		chk("diag", diag_output, guard_closed && handle_defined && !warn && !err);
		chk("lock", lock_drive, lk);
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic count_rise(input int sel, input int ncyc, output int r);
		logic prev, cur;
		r = 0;
		prev = leds[sel];
		repeat (ncyc) begin
			@(posedge mclk);
			#1;
			cur = leds[sel];
			if (cur && !prev) r++;
			prev = cur;
		end
	endtask
	task automatic wait_nv(input int bound, output int t);
		t = 0;
		do begin
			@(posedge mclk);
			#1;
			t++;
			if (t > bound) begin
				error_cnt++;
				$display("BAD %0t no store write", $time);
				report_and_stop();
			end
		end while (nv_write !== 1'b1);
	endtask
	task automatic set_cfg(input logic p, input logic d, input logic req);
		@(posedge mclk);
		power_to_lock <= p;
		door_monitor <= d;
		lreq <= req;
		magnet_cmd <= p ? req : !req;
	endtask
	task automatic reopen;
		@(posedge mclk);
		guard_closed <= 1'b0;
		settle(4);
		@(posedge mclk);
		guard_closed <= 1'b1;
		settle(4);
	endtask
	task automatic power_up(input logic ind, input logic rep, input logic [7:0] k);
		@(posedge mclk);
		reset <= 1'b1;
		individual_coded <= ind;
		teach_repeatable <= rep;
		act_code <= k;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rng = xs(rng);
		c = rng[7:0];
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		act_code <= c;
		settle(6);
		for (int p = 0; p < 2; p++) begin
			for (int d = 0; d < 2; d++) begin
				set_cfg(p[0], d[0], 1'b1);
				settle(4);
				chk_out(0, 0, 0);
				set_cfg(p[0], d[0], 1'b0);
				settle(4);
				chk_out(0, 0, 0);
				@(posedge mclk);
				guard_closed <= 1'b0;
				settle(4);
				chk_out(0, 0, 0);
				@(posedge mclk);
				guard_closed <= 1'b1;
				settle(4);
			end
		end
		set_cfg(1'b0, 1'b0, 1'b1);
		settle(4);
		@(posedge mclk);
		handle_defined <= 1'b0;
		settle(4);
		chk_out(1, 0, 0);
		count_rise(1, 9 * SLOT, n);
		chk("six pulses", n == 6, 1'b1);
		@(posedge mclk);
		handle_defined <= 1'b1;
		reopen();
		chk_out(0, 0, 0);
		@(posedge mclk);
		faults <= sic_pkg::sic_fault_t'(8'h01);
		settle(4);
		chk_out(1, 0, 0);
		count_rise(1, 400, n);
		chk("steady red", leds.red && n == 0, 1'b1);
		@(posedge mclk);
		faults <= '0;
		settle(4);
		chk_out(1, 0, 0);
		reopen();
		chk_out(0, 0, 0);
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			faults <= sic_pkg::sic_fault_t'(wmask[k]);
			settle(4);
			chk_out(0, 1, 0);
			count_rise(1, (k + 4) * SLOT, n);
			chk("warning pulses", n == k + 1, 1'b1);
			chk_out(0, 1, 1);
			@(posedge mclk);
			faults <= '0;
			settle(4);
			chk_out(0, 0, 0);
		end
		@(posedge mclk);
		faults <= sic_pkg::sic_fault_t'(8'h20);
		settle(4);
		chk_out(0, 0, 0);
		@(posedge mclk);
		guard_closed <= 1'b0;
		settle(4);
		count_rise(1, 4 * SLOT, n);
		chk("foreign voltage", n == 1, 1'b1);
		@(posedge mclk);
		faults <= '0;
		guard_closed <= 1'b1;
		settle(4);
		@(posedge mclk);
		if (rng[8]) safety_input_a <= 1'b0;
		else safety_input_b <= 1'b0;
		settle(4);
		chk_out(0, 0, 0);
		count_rise(2, 4000, n);
		chk("green blink", n == 1 && !leds.red && leds.yellow, 1'b1);
		@(posedge mclk);
		safety_input_a <= 1'b1;
		safety_input_b <= 1'b1;
		power_up(1'b1, 1'b0, c);
		settle(6);
		chk("teach leds", !leds.green && leds.red, 1'b1);
		wait_nv(TEACH * TK + 20, took);
		chk("teach time", took + 6 >= TEACH * TK, 1'b1);
		chk_nv(nv_out, mk_nv(c, 1'b0, 1'b1, 1'b0));
		power_up(1'b1, 1'b0, c);
		wait_nv(20, took);
		chk_nv(nv_out, mk_nv(c, 1'b1, 1'b0, 1'b0));
		settle(4);
		chk_out(0, 0, 0);
		power_up(1'b1, 1'b0, c + 8'h01);
		settle(8);
		chk_out(1, 0, 0);
		chk_nv(nv_in, mk_nv(c, 1'b1, 1'b0, 1'b0));
		power_up(1'b1, 1'b1, c + 8'h01);
		wait_nv(TEACH * TK + 20, took);
		chk_nv(nv_out, mk_nv(c + 8'h01, 1'b0, 1'b1, 1'b1));
		power_up(1'b1, 1'b1, c + 8'h01);
		wait_nv(20, took);
		chk_nv(nv_out, mk_nv(c + 8'h01, 1'b1, 1'b0, 1'b1));
		settle(4);
		chk("inhibit", safety_output_a || safety_output_b, 1'b0);
		settle(INH * TK / 2);
		power_up(1'b1, 1'b1, c + 8'h01);
		wait_nv(INH * TK + 40, took);
		chk("full inhibit", took >= INH * TK, 1'b1);
		chk_nv(nv_out, mk_nv(c + 8'h01, 1'b1, 1'b0, 1'b0));
		settle(4);
		chk_out(0, 0, 0);
		power_up(1'b1, 1'b1, c + 8'h02);
		wait_nv(TEACH * TK + 20, took);
		chk_nv(nv_out, mk_nv(c + 8'h02, 1'b0, 1'b1, 1'b1));
		wait_nv(POFF * TK + 20, took);
		chk("abort", took >= POFF * TK && !nv_out.pending, 1'b1);
		settle(4);
		count_rise(1, 8 * SLOT, n);
		chk("five pulses", n == 5 && !safety_output_a, 1'b1);
		report_and_stop();
	end
endmodule
`default_nettype wire
